// ### design/sti_cfg.svh
/*
 * Character codes, command letters, memory map and reset values for the
 * serial telegram read interpreter.
 * Assumes: included by bare name from the design files, definitions only.
 */
`ifndef STI_CFG_SVH
`define STI_CFG_SVH

// ----------------------------------------------------------------------
// Line control characters, hash and decimal digit range
// ----------------------------------------------------------------------
`define STI_STX 8'h02
`define STI_ETX 8'h03
`define STI_ENQ 8'h05
`define STI_ACK 8'h06
`define STI_NAK 8'h15
`define STI_CR 8'h0d
`define STI_LF 8'h0a
`define STI_HASH 8'h23
`define STI_ZERO 8'h30
`define STI_NINE 8'h39

// ----------------------------------------------------------------------
// Command letters (first and second body character)
// ----------------------------------------------------------------------
`define STI_CMD_RD 8'h44
`define STI_CMD_WR 8'h57
`define STI_OBJ_WORD 8'h52
`define STI_OBJ_BLK 8'h41
`define STI_OBJ_BLK3 8'h42
`define STI_OBJ_CNT 8'h43
`define STI_OBJ_ELEM 8'h45
`define STI_OBJ_TVAL 8'h4d
`define STI_OBJ_TVAL5 8'h6d
`define STI_OBJ_TBLK 8'h4e
`define STI_OBJ_TBLK3 8'h6e

// ----------------------------------------------------------------------
// Variant code, memory map and reset values
// ----------------------------------------------------------------------
`define STI_TERM_VARIANT_CODE 8'h00
`define STI_REG_WORDS 1000
`define STI_TXT_WORDS 8192
`define STI_ADDR_W 14
`define STI_TX_RST 8'h00

`endif

// ### design/sti_pkg.sv
/*
 * Types shared by the serial telegram read interpreter files.
 * Assumes: compiled before the design modules.
 */
package sti_pkg;

    // ------------------------------------------------------------------
    // Controller state, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [15:0] {
        S_IDLE = 16'h0001, S_BODY = 16'h0002, S_CHK = 16'h0004,
        S_EXEC = 16'h0008, S_HDR = 16'h0010, S_RDL = 16'h0020,
        S_RDH = 16'h0040, S_LOAD = 16'h0080, S_DIG = 16'h0100,
        S_ETX = 16'h0200, S_BCC = 16'h0400, S_CR = 16'h0800,
        S_LF = 16'h1000, S_NAK = 16'h2000, S_ACK = 16'h4000,
        S_CWAIT = 16'h8000
    } sti_state_t;

    // Port assignment chosen by the controller program
    typedef enum logic [1:0] {
        M_TEXT = 2'h0, M_CHAR = 2'h1, M_NUM = 2'h2, M_TEL = 2'h3
    } sti_mode_t;

    // ------------------------------------------------------------------
    // Whole state of the interpreter
    // ------------------------------------------------------------------
    typedef struct packed {
        sti_state_t st;
        logic simple_terminal_variant;
        logic [7:0] c0;
        logic [7:0] c1;
        logic [1:0] pos;
        logic [13:0] acc;
        logic [2:0] dcnt;
        logic [3:0] ld;
        logic [3:0] xv;
        logic bad;
        logic [7:0] bcc;
        logic [13:0] ptr;
        logic [3:0] cnt;
        logic bin;
        logic [2:0] nd;
        logic [19:0] dig;
        logic [7:0] lo;
        logic cread;
        logic cnt_ok;
        logic [9:0] cadr;
        logic creq;
        logic ew;
        logic [9:0] ea;
        logic ev;
        logic txv;
        logic [7:0] txd;
    } sti_regs_t;

endpackage

// ### design/sti_mem.sv
/*
 * Byte memory holding word registers and the text memory.
 * Assumes: one clock, write port fed by controller logic, read data
 * registered so the reader sees it one enabled edge after the address.
 */
`timescale 1ns/1ps
module sti_mem #(
    parameter int DEPTH = 9192,
    parameter int AW = 14
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [DEPTH];

    // ------------------------------------------------------------------
    // Storage, out-of-range addresses are dropped and read as zero
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (ce && we && (32'(waddr) < DEPTH)) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read keeps the memory inferable as block RAM
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= (32'(raddr) < DEPTH) ? mem[raddr] : 8'h00;
        end
    end
endmodule

// ### design/sti_read_interp.sv
/*
 * Serial telegram interpreter: takes framed read telegrams from the
 * character layer, fetches word registers or text memory and frames the
 * reply; also element write, counter enquiry, abort and NAK handling.
 * Assumes: RX/TX byte streams and memory/counter ports on SYS_CLK.
 */
`timescale 1ns/1ps
`include "sti_cfg.svh"
module sti_read_interp #(
    parameter int REG_WORDS = `STI_REG_WORDS,
    parameter int TXT_WORDS = `STI_TXT_WORDS
) (
    // Clock, reset, enable
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic CLK_EN,
    // Received characters
    input wire logic [7:0] RX_DATA,
    input wire logic RX_VALID,
    // Transmitted characters
    output logic [7:0] TX_DATA,
    output logic TX_VALID,
    input wire logic TX_READY,
    // Port configuration
    input wire sti_pkg::sti_mode_t ASSIGN_MODE,
    input wire logic [7:0] VARIANT_CODE,
    // Memory load port
    input wire logic MEM_WE,
    input wire logic [13:0] MEM_WADDR,
    input wire logic [7:0] MEM_WDATA,
    // Element write
    output logic ELEM_WE,
    output logic [9:0] ELEM_ADDR,
    output logic ELEM_VALUE,
    // Counter fetch
    output logic CNT_REQ,
    output logic [9:0] CNT_ADDR,
    input wire logic CNT_ACK,
    input wire logic [15:0] CNT_DATA
);
    import sti_pkg::*;

    sti_regs_t q, d;
    logic [7:0] rdata;
    logic [7:0] ch;
    logic [4:0] sp;
    logic [13:0] rbase;
    logic tel_en, ok, isbin, istxt;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic is_digit(input logic [7:0] c);
        return (c >= `STI_ZERO) && (c <= `STI_NINE);
    endfunction

    function automatic logic is_txt(input logic [7:0] c);
        return (c == `STI_OBJ_TVAL) || (c == `STI_OBJ_TVAL5) ||
               (c == `STI_OBJ_TBLK) || (c == `STI_OBJ_TBLK3);
    endfunction

    // Address digits: four for text memory, three otherwise
    function automatic logic [2:0] alen(input logic [7:0] c);
        return is_txt(c) ? 3'h4 : 3'h3;
    endfunction

    // Locations covered by a read, zero for unsupported objects
    function automatic logic [4:0] span(input logic [7:0] c);
        unique case (c)
            `STI_OBJ_WORD: return 5'h01;
            `STI_OBJ_BLK: return 5'h05;
            `STI_OBJ_BLK3: return 5'h0f;
            `STI_OBJ_TVAL: return 5'h02;
            `STI_OBJ_TVAL5: return 5'h0a;
            `STI_OBJ_TBLK: return 5'h05;
            `STI_OBJ_TBLK3: return 5'h0f;
            default: return 5'h00;
        endcase
    endfunction

    function automatic logic [13:0] dec_acc(input logic [13:0] a,
                                            input logic [3:0] dg);
        return 14'(a * 14'h000a + {10'h000, dg});
    endfunction

    // Binary to five decimal digits, shift-and-add-three
    function automatic logic [19:0] bin2bcd(input logic [15:0] b);
        logic [35:0] s;
        s = {20'h00000, b};
        for (int i = 0; i < 16; i++) begin
            for (int j = 0; j < 5; j++) begin
                if (s[16+4*j +: 4] > 4'h4) begin
                    s[16+4*j +: 4] = s[16+4*j +: 4] + 4'h3;
                end
            end
            s = s << 1;
        end
        return s[35:16];
    endfunction

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    sti_mem #(.DEPTH(REG_WORDS + TXT_WORDS), .AW(`STI_ADDR_W)) u_mem (
        .clk(SYS_CLK),
        .rst(RESET),
        .ce(CLK_EN),
        .we(MEM_WE),
        .waddr(MEM_WADDR),
        .wdata(MEM_WDATA),
        .raddr(q.ptr),
        .rdata(rdata)
    );

    // ------------------------------------------------------------------
    // Telegram decode
    // ------------------------------------------------------------------
    // Text and single-character assignments keep the telegram path shut
    assign tel_en = (ASSIGN_MODE == M_NUM) || (ASSIGN_MODE == M_TEL);
    assign sp = span(q.c1);
    assign isbin = (q.c1 == `STI_OBJ_TVAL) || (q.c1 == `STI_OBJ_TVAL5);
    assign istxt = is_txt(q.c1);
    assign rbase = istxt ? 14'(REG_WORDS) : 14'h0000;

    // Anything not recognised, short of digits or out of range is refused
    always_comb begin
        ok = 1'b0;
        if (!q.bad && q.pos == 2'h2) begin
            if (q.c0 == `STI_CMD_WR) begin
                ok = (q.c1 == `STI_OBJ_ELEM) && (q.dcnt == 3'h4) &&
                     (q.xv <= 4'h1);
            end else if (q.c0 == `STI_CMD_RD) begin
                ok = (q.dcnt == alen(q.c1)) &&
                     ((q.c1 == `STI_OBJ_CNT) ||
                      ((sp != 5'h00) &&
                       (q.acc + 14'h0001 >= {9'h000, sp}) &&
                       (!isbin || q.acc[0]) &&
                       (!istxt || q.acc < 14'(TXT_WORDS)) &&
                       (isbin || !istxt ||
                        q.ld == 4'h4 || q.ld == 4'h9)));
            end
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        ch = `STI_ZERO | {4'h0, q.dig[19:16]};
        d.creq = 1'b0;
        d.ew = 1'b0;
        if (q.txv && TX_READY) begin
            d.txv = 1'b0;
        end
        unique case (q.st)
            S_IDLE: begin
                d.simple_terminal_variant =
                    (VARIANT_CODE == `STI_TERM_VARIANT_CODE);
                if (RX_VALID && tel_en) begin
                    if (RX_DATA == `STI_STX) begin
                        d.st = S_BODY;
                        d.pos = 2'h0;
                        d.acc = 14'h0000;
                        d.dcnt = 3'h0;
                        d.bad = 1'b0;
                        d.bcc = 8'h00;
                        d.cread = 1'b0;
                    end else if (RX_DATA == `STI_ENQ) begin
                        // Enquiry after a counter read fetches the value
                        d.creq = q.cnt_ok;
                        d.st = q.cnt_ok ? S_CWAIT : S_NAK;
                    end else if (RX_DATA == `STI_ACK) begin
                        d.cnt_ok = 1'b0;
                    end
                end
            end
            S_BODY: if (RX_VALID) begin
                d.bcc = q.bcc ^ RX_DATA;
                if (RX_DATA == `STI_ENQ) begin
                    d.st = S_NAK;
                end else if (RX_DATA == `STI_ETX) begin
                    d.st = q.simple_terminal_variant ? S_EXEC : S_CHK;
                end else if (q.pos == 2'h0) begin
                    d.c0 = RX_DATA;
                    d.pos = 2'h1;
                end else if (q.pos == 2'h1) begin
                    d.c1 = RX_DATA;
                    d.pos = 2'h2;
                end else if (is_digit(RX_DATA)) begin
                    if (q.dcnt < alen(q.c1)) begin
                        d.acc = dec_acc(q.acc, RX_DATA[3:0]);
                        d.ld = RX_DATA[3:0];
                    end else begin
                        d.xv = RX_DATA[3:0];
                    end
                    if (q.dcnt != 3'h7) begin
                        d.dcnt = q.dcnt + 3'h1;
                    end
                end else begin
                    d.bad = 1'b1;
                end
            end
            // ENQ in place of the check character also aborts
            S_CHK: if (RX_VALID) begin
                d.st = (RX_DATA == `STI_ENQ || RX_DATA != q.bcc) ?
                       S_NAK : S_EXEC;
            end
            S_EXEC: begin
                if (!ok) begin
                    d.st = S_NAK;
                end else if (q.c0 == `STI_CMD_WR) begin
                    d.ew = 1'b1;
                    d.ea = q.acc[9:0];
                    d.ev = q.xv[0];
                    d.st = S_ACK;
                end else if (q.c1 == `STI_OBJ_CNT) begin
                    d.cnt_ok = 1'b1;
                    d.cadr = q.acc[9:0];
                    d.st = S_ACK;
                end else begin
                    // Walk upward from the lowest location of the span
                    d.ptr = 14'(rbase + q.acc + 14'h0001 - {9'h000, sp});
                    d.cnt = isbin ? sp[4:1] : sp[3:0];
                    d.bin = isbin;
                    d.bcc = 8'h00;
                    d.st = S_HDR;
                end
            end
            S_HDR: if (!q.txv) begin
                d.txv = 1'b1;
                d.txd = `STI_STX;
                d.st = q.cread ? S_DIG : S_RDL;
            end
            S_RDL: begin
                d.ptr = q.ptr + 14'h0001;
                d.st = q.bin ? S_RDH : S_LOAD;
            end
            S_RDH: begin
                d.lo = rdata;
                d.ptr = q.ptr + 14'h0001;
                d.st = S_LOAD;
            end
            // High byte at the odd address, low byte just below it
            S_LOAD: begin
                d.dig = q.bin ? bin2bcd({rdata, q.lo}) : {rdata, 12'h000};
                d.nd = q.bin ? 3'h5 : 3'h2;
                d.st = S_DIG;
            end
            S_DIG: if (!q.txv) begin
                d.txv = 1'b1;
                d.txd = ch;
                d.bcc = q.bcc ^ ch;
                d.dig = q.dig << 4;
                d.nd = q.nd - 3'h1;
                if (q.nd == 3'h1) begin
                    d.cnt = q.cnt - 4'h1;
                    d.st = (q.cnt == 4'h1) ? S_ETX : S_RDL;
                end
            end
            S_ETX: if (!q.txv) begin
                d.txv = 1'b1;
                d.txd = `STI_ETX;
                d.bcc = q.bcc ^ `STI_ETX;
                d.st = q.simple_terminal_variant ? S_CR : S_BCC;
            end
            S_BCC: if (!q.txv) begin
                d.txv = 1'b1;
                d.txd = q.bcc;
                d.st = S_IDLE;
            end
            S_CR: if (!q.txv) begin
                d.txv = 1'b1;
                d.txd = `STI_CR;
                d.st = S_LF;
            end
            S_LF: if (!q.txv) begin
                d.txv = 1'b1;
                d.txd = `STI_LF;
                d.st = S_IDLE;
            end
            S_NAK: if (!q.txv) begin
                d.txv = 1'b1;
                d.txd = q.simple_terminal_variant ?
                        `STI_HASH : `STI_NAK;
                d.st = q.simple_terminal_variant ? S_CR : S_IDLE;
            end
            S_ACK: begin
                if (q.simple_terminal_variant) begin
                    d.st = S_CR;
                end else if (!q.txv) begin
                    d.txv = 1'b1;
                    d.txd = `STI_ACK;
                    d.st = S_IDLE;
                end
            end
            S_CWAIT: if (CNT_ACK) begin
                d.dig = bin2bcd(CNT_DATA);
                d.nd = 3'h5;
                d.cnt = 4'h1;
                d.cread = 1'b1;
                d.bcc = 8'h00;
                d.st = S_HDR;
            end
        endcase
    end

    // State register; a low enable freezes everything
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            q <= '0;
            q.st <= S_IDLE;
            q.txd <= `STI_TX_RST;
        end else if (CLK_EN) begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign TX_DATA = q.txd;
    assign TX_VALID = q.txv;
    assign ELEM_WE = q.ew;
    assign ELEM_ADDR = q.ea;
    assign ELEM_VALUE = q.ev;
    assign CNT_REQ = q.creq;
    assign CNT_ADDR = q.cadr;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET || !CLK_EN);

    sequence s_nak_out;
        TX_VALID && (TX_DATA == `STI_NAK || TX_DATA == `STI_HASH);
    endsequence
    sequence s_enq_in_body;
        q.st == S_BODY && RX_VALID && RX_DATA == `STI_ENQ;
    endsequence

    chk_enq_abort: assert property (s_enq_in_body |-> ##[1:3] s_nak_out)
        else $error("abort by ENQ did not produce NAK");
    chk_tx_hold: assert property (TX_VALID && !TX_READY |=>
        TX_VALID && $stable(TX_DATA))
        else $error("TX byte changed before it was taken");
    chk_simple_no_bcc: assert property (q.simple_terminal_variant |->
        q.st != S_BCC)
        else $error("check character sent in simple terminal variant");
    chk_elem_crlf: assert property (q.st == S_EXEC && ok &&
        q.simple_terminal_variant && q.c0 == `STI_CMD_WR |->
        ##[1:6] TX_VALID && TX_DATA == `STI_CR)
        else $error("element write not answered with CR");
    chk_tel_gate: assert property (q.st == S_IDLE && !tel_en |=>
        q.st == S_IDLE)
        else $error("telegram taken under a text-only assignment");
    chk_cnt_req: assert property ($rose(CNT_REQ) |->
        $past(RX_VALID && RX_DATA == `STI_ENQ && q.cnt_ok))
        else $error("counter fetched without stored address and ENQ");
    chk_bad_nak: assert property (q.st == S_EXEC && !ok |=>
        q.st == S_NAK)
        else $error("unsupported telegram not refused");
    chk_frame_open: assert property (q.st == S_HDR && !q.txv |=>
        TX_VALID && TX_DATA == `STI_STX)
        else $error("reply frame did not open with STX");
    chk_digit_ascii: assert property (q.st == S_DIG && !q.txv |=>
        TX_DATA >= `STI_ZERO && TX_DATA <= `STI_NINE)
        else $error("reply digit not ASCII decimal");
    chk_variant_sel: assert property (q.st == S_IDLE |=>
        q.simple_terminal_variant ==
        $past(VARIANT_CODE == `STI_TERM_VARIANT_CODE))
        else $error("variant not taken from code");
    chk_blk_count: assert property (q.st == S_EXEC && ok &&
        q.c0 == `STI_CMD_RD && q.c1 == `STI_OBJ_BLK |=> q.cnt == 4'h5)
        else $error("register block not five words");
    chk_blk3_count: assert property (q.st == S_EXEC && ok &&
        q.c0 == `STI_CMD_RD && q.c1 == `STI_OBJ_BLK3 |=> q.cnt == 4'hf)
        else $error("triple block not fifteen words");
endmodule

// ### tb/sti_host_model.sv
/*
 * Host side of the serial line: takes reply characters and answers
 * counter fetches.
 * Assumes: shares the interpreter clock and its enable, so a frozen
 * cycle freezes both sides alike; slow selects a stalling host.
 */
`timescale 1ns/1ps
module sti_host_model (
    // Clock and pace
    input wire logic clk,
    input wire logic ce,
    input wire logic slow,
    // Reply characters
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready = 1'b0,
    // Counter fetch
    input wire logic cnt_req,
    output logic cnt_ack = 1'b0,
    output logic [15:0] cnt_data = 16'h5a5a,
    input wire logic [15:0] cnt_value
);
    byte unsigned rxq[$];
    logic [3:0] cyc = 4'h0;
    int cd = 0;
    // Take replies; a slow host stalls three cycles of four
    always @(posedge clk) begin
        if (ce) begin
            cyc <= cyc + 4'h1;
            if (tx_valid && tx_ready) rxq.push_back(tx_data);
            tx_ready <= !slow || (cyc[1:0] == 2'h3);
        end
    end
    // Counter value only valid with the strobe, garbage otherwise
    always @(posedge clk) begin
        if (ce) begin
            cnt_ack <= 1'b0;
            cnt_data <= ~cnt_data;
            if (cnt_req) cd <= slow ? 6 : 1;
            else if (cd > 0) cd <= cd - 1;
            if (cd == 1) begin
                cnt_ack <= 1'b1;
                cnt_data <= cnt_value;
            end
        end
    end
endmodule

// ### tb/sti_read_interp_tb_top.sv
/*
 * Self-checking bench for the read interpreter, with a byte model.
 * Assumes: design files and sti_host_model compiled first.
 */
`timescale 1ns/1ps
`include "sti_cfg.svh"
module sti_read_interp_tb_top;
    import sti_pkg::*;
    logic sys_clk = 0, reset = 1, rx_valid = 0, mem_we = 0, slow = 0;
    logic clk_en = 1;
    logic [7:0] rx_data = 0, variant = 8'h01, mem_wdata = 0, tx_data;
    logic [13:0] mem_waddr = 0;
    logic [15:0] rnd = 16'h000b, cnt_value = 0, cnt_data;
    logic tx_valid, tx_ready, elem_we, elem_value, cnt_req, cnt_ack;
    logic [9:0] elem_addr, cnt_addr, ew_a, cr_a;
    sti_mode_t mode = M_TEL;
    logic [7:0] mm [0:1999];
    byte unsigned ex[$];
    int bad_count = 0, n_checks = 0, ew_n = 0;
    logic ew_v;

    always #5 sys_clk = ~sys_clk;

    sti_read_interp sti_read_interp_i (.SYS_CLK(sys_clk), .RESET(reset),
        .CLK_EN(clk_en), .RX_DATA(rx_data), .RX_VALID(rx_valid),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .ASSIGN_MODE(mode), .VARIANT_CODE(variant), .MEM_WE(mem_we),
        .MEM_WADDR(mem_waddr), .MEM_WDATA(mem_wdata), .ELEM_WE(elem_we),
        .ELEM_ADDR(elem_addr), .ELEM_VALUE(elem_value), .CNT_REQ(cnt_req),
        .CNT_ADDR(cnt_addr), .CNT_ACK(cnt_ack), .CNT_DATA(cnt_data));
    sti_host_model host (.clk(sys_clk), .ce(clk_en), .slow(slow),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .cnt_req(cnt_req),
        .cnt_ack(cnt_ack), .cnt_data(cnt_data), .cnt_value(cnt_value));

    // Capture one-cycle pulses where they stand
    always @(posedge sys_clk) begin
        // A pulse stands through frozen cycles, so count enabled edges only
        if (elem_we === 1'b1 && clk_en) begin
            ew_n++;
            ew_a = elem_addr;
            ew_v = elem_value;
        end
        if (cnt_req === 1'b1) cr_a = cnt_addr;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic send(input byte unsigned s[$]);
        foreach (s[i]) begin
            @(posedge sys_clk);
            rx_data <= s[i];
            rx_valid <= 1'b1;
        end
        @(posedge sys_clk);
        rx_valid <= 1'b0;
    endtask

    // Frame a telegram; the check character is XOR after STX through ETX
    task automatic tel(input string b);
        byte unsigned s[$];
        byte unsigned x;
        x = `STI_ETX;
        s.push_back(`STI_STX);
        for (int i = 0; i < b.len(); i++) begin
            s.push_back(b[i]);
            x ^= b[i];
        end
        s.push_back(`STI_ETX);
        if (variant != 8'h00) s.push_back(x);
        send(s);
    endtask

    // Bounded wait, then a quiet spell so extra characters are seen
    task automatic expect_reply;
        int t;
        t = 0;
        while (host.rxq.size() < ex.size() && t < 3000) begin
            @(posedge sys_clk);
            // Random freezes while the reply runs, never while RX is fed
            rnd = lfsr(rnd);
            clk_en <= (rnd[2:0] != 3'h0);
            t++;
        end
        @(posedge sys_clk);
        clk_en <= 1'b1;
        repeat (19) @(posedge sys_clk);
        chk(host.rxq.size(), ex.size());
        foreach (ex[i]) begin
            if (i < host.rxq.size()) chk(host.rxq[i], ex[i]);
        end
        host.rxq.delete();
        ex.delete();
    endtask

    task automatic bcd(input int a, input int n);
        for (int k = a - n + 1; k <= a; k++) begin
            ex.push_back(8'h30 + mm[k][7:4]);
            ex.push_back(8'h30 + mm[k][3:0]);
        end
    endtask

    task automatic dec5(input int v);
        for (int d = 10000; d > 0; d /= 10) ex.push_back(8'h30 + (v / d) % 10);
    endtask

    task automatic data_reply;
        byte unsigned x;
        x = `STI_ETX;
        foreach (ex[i]) x ^= ex[i];
        ex.push_front(`STI_STX);
        ex.push_back(`STI_ETX);
        if (variant != 8'h00) ex.push_back(x);
        else ex = {ex, `STI_CR, `STI_LF};
        expect_reply();
    endtask

    task automatic nak;
        if (variant != 8'h00) ex = {`STI_NAK};
        else ex = {`STI_HASH, `STI_CR, `STI_LF};
        expect_reply();
    endtask

    task automatic ack;
        if (variant != 8'h00) ex = {`STI_ACK};
        else ex = {`STI_CR, `STI_LF};
        expect_reply();
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        chk(tx_valid, 1'b0);
        // Random packed BCD into registers 0..29 and text 0..29
        for (int a = 0; a < 60; a++) begin
            rnd = lfsr(rnd);
            @(posedge sys_clk);
            mem_we <= 1'b1;
            mem_waddr <= 14'(a < 30 ? a : a + 970);
            mem_wdata <= {4'(rnd[7:0] % 10), 4'(rnd[15:8] % 10)};
            mm[a < 30 ? a : a + 970] = {4'(rnd[7:0] % 10), 4'(rnd[15:8] % 10)};
        end
        @(posedge sys_clk);
        mem_we <= 1'b0;
        // Checked variant with a prompt host, then terminal with stalls
        for (int p = 0; p < 2; p++) begin
            variant <= p ? `STI_TERM_VARIANT_CODE : 8'h01;
            slow <= p[0];
            @(posedge sys_clk);
            tel("DR005"); bcd(5, 1); data_reply();
            tel("DA009"); bcd(9, 5); data_reply();
            tel("DB029"); bcd(29, 15); data_reply();
            tel("DM0003"); dec5({mm[1003], mm[1002]}); data_reply();
            tel("Dm0019");
            for (int h = 11; h <= 19; h += 2) dec5({mm[1000 + h], mm[999 + h]});
            data_reply();
            tel("DN0014"); bcd(1014, 5); data_reply();
            tel("Dn0029"); bcd(1029, 15); data_reply();
            tel("DM0004"); nak();
            tel("DN0015"); nak();
            tel("DX005"); nak();
            send({`STI_STX, 8'h44, 8'h52, 8'h30, `STI_ENQ}); nak();
            $display("read set %0d done", p);
        end
        // Element write and counter exchange on the terminal variant
        tel("WE0341"); ack();
        chk({ew_n[7:0], ew_a, ew_v}, {8'd1, 10'd34, 1'b1});
        cnt_value <= 16'd19083;
        tel("DC256"); ack();
        send({`STI_ENQ}); dec5(19083); data_reply();
        chk(cr_a, 10'd256);
        send({`STI_ACK});
        send({`STI_ENQ}); nak();
        $display("element and counter done");
        // Wrong check character, then assignment modes
        variant <= 8'h01;
        send({`STI_STX, 8'h44, 8'h52, 8'h30, 8'h30, 8'h35, `STI_ETX, 8'hff});
        nak();
        mode <= M_CHAR;
        tel("DR005"); expect_reply();
        mode <= M_TEXT;
        tel("DR005"); expect_reply();
        mode <= M_NUM;
        tel("DR005"); bcd(5, 1); data_reply();
        $display("framing and modes done");
        conclude();
    end

    // Watchdog sized well beyond the expected run
    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        conclude();
    end
endmodule
